// [hw/nvm_byte_access.sv]
// Indirect byte access to a 64-byte nonvolatile data store through four registers.
// Assumes a core on core_clk driving the register port, and reset/watchdog pins from outside.
// Function
// - Store holds 64 bytes at 0h-3Fh.
// - Reads and writes work in normal operation.
// - Access only through four registers.
// - Data holds byte, address holds location.
// - Access is one byte at a time.
// - Each write erases, then programs the byte.
// - On-chip timer sets write duration.
// - Protection blocks programmer, not the core.
// - Address register eight bits, 64 implemented.
// - Upper two address bits must be zero.
// - Read trigger set-only, hardware clears it.
// - Write trigger set-only, cleared when done.
// - Reset during write sets abort flag.
`timescale 1ns/1ps

module nvm_byte_access #(
    parameter int WRITE_TICKS = nvm_pkg::WRITE_TICKS_DEF // Timer ticks per whole write.
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire nvm_pkg::sfr_req_s  sfr_req,
    input  wire logic [1:0]         sfr_ridx,
    output logic      [7:0]         sfr_rdata,
    input  wire logic               external_reset_pin_n,
    input  wire logic               watchdog_timer_reset,
    input  wire logic               code_protect,
    input  wire nvm_pkg::prog_req_s prog_req,
    output logic      [7:0]         prog_rdata,
    output logic                    write_busy
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM} wstate_e;

    wstate_e     state_r;         // Write sequencer state.
    logic        rd_r;            // Read trigger bit.
    logic        wr_r;            // Write trigger bit.
    logic        permit_r;        // Write permit bit.
    logic        abort_r;         // Write aborted flag.
    logic        done_r;          // Write completed flag.
    logic [7:0]  data_r;          // Data holding register.
    logic [7:0]  loc_r;           // Location select register.
    logic [7:0]  wr_data_r;       // Byte captured at write start.
    logic [5:0]  wr_addr_r;       // Place captured at write start.
    logic        erase_go_r;      // One-cycle pulse that erases the place.
    logic        rd_ok_r;         // Pending read hit an implemented place.
    logic [6:0]  tick_cnt_r;      // Divider for the write timer tick.
    logic [15:0] wticks_r;        // Ticks spent in the current write.
    logic        tick;            // One-cycle timer enable.
    logic        ext_meta_r;      // Reset pin, first sync stage.
    logic        ext_sync_r;      // Reset pin, second sync stage.
    logic        wdt_meta_r;      // Watchdog reset, first sync stage.
    logic        wdt_sync_r;      // Watchdog reset, second sync stage.
    logic        soft_rst;        // Pin or watchdog reset seen by the core.
    logic        ctl_wr;          // Core writes the control register.
    logic        loc_ok;          // Location select names an implemented place.
    logic        rd_start;        // A read begins this cycle.
    logic        wr_start;        // A write begins this cycle.
    logic        erase_end;       // Erase phase ends this cycle.
    logic        finish;          // Program phase ends this cycle.
    logic        prog_ok;         // Programmer access allowed.
    logic        prog_rd_r;       // Programmer read pending.
    logic        mem_we;          // Array write enable.
    logic [5:0]  mem_waddr;       // Array write place.
    logic [7:0]  mem_wdata;       // Array write byte.
    logic        mem_re;          // Array read enable.
    logic [5:0]  mem_raddr;       // Array read place.
    logic [7:0]  mem_rdata;       // Array read byte.

    localparam logic [6:0]  TICK_LAST  = 7'(nvm_pkg::TICK_CYCLES - 1);
    localparam logic [15:0] ERASE_LAST = 16'(WRITE_TICKS / 2 - 1);
    localparam logic [15:0] WRITE_LAST = 16'(WRITE_TICKS - 1);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Both resets come from other clock sources, so each passes two flops.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_meta_r <= 1'b1;
            ext_sync_r <= 1'b1;
            wdt_meta_r <= 1'b0;
            wdt_sync_r <= 1'b0;
        end else begin
            ext_meta_r <= external_reset_pin_n;
            ext_sync_r <= ext_meta_r;
            wdt_meta_r <= watchdog_timer_reset;
            wdt_sync_r <= wdt_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // normal operation gating
    assign soft_rst = !ext_sync_r || wdt_sync_r;
    assign ctl_wr   = sfr_req.wr && (sfr_req.idx == nvm_pkg::IDX_CONTROL);
    assign loc_ok   = (loc_r[7:6] == nvm_pkg::TOP_BITS_OK);
    assign rd_start = ctl_wr && sfr_req.wdata[nvm_pkg::BIT_RD] && !rd_r && !soft_rst;
    assign wr_start = ctl_wr && sfr_req.wdata[nvm_pkg::BIT_WR] && permit_r && loc_ok
                      && (state_r == ST_IDLE) && !soft_rst;
    assign erase_end = (state_r == ST_ERASE) && tick && (wticks_r == ERASE_LAST);
    assign finish    = (state_r == ST_PROGRAM) && tick && (wticks_r == WRITE_LAST);
    assign write_busy = (state_r != ST_IDLE);

    // ----------------------------------------------------------------
    // Write timer
    // ----------------------------------------------------------------
    // on-chip tick divider
    // The divider runs freely so write length does not depend on core activity.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 7'h00;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 7'h00;
        end else begin
            tick_cnt_r <= tick_cnt_r + 7'h01;
        end
    end
    assign tick = (tick_cnt_r == TICK_LAST);

    // Ticks spent in a write; cleared while idle.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wticks_r <= 16'h0000;
        end else if (state_r == ST_IDLE || soft_rst) begin
            wticks_r <= 16'h0000;
        end else if (tick) begin
            wticks_r <= wticks_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Write sequencer
    // ----------------------------------------------------------------
    // erase then program
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else if (soft_rst) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (wr_start) begin
                        state_r <= ST_ERASE;
                    end
                end
                ST_ERASE: begin
                    if (erase_end) begin
                        state_r <= ST_PROGRAM;
                    end
                end
                ST_PROGRAM: begin
                    if (finish) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Capture place and byte at start, so later register writes cannot tear the write.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_addr_r  <= 6'h00;
            wr_data_r  <= 8'h00;
            erase_go_r <= 1'b0;
        end else begin
            erase_go_r <= wr_start;
            if (wr_start) begin
                wr_addr_r <= loc_r[5:0];
                wr_data_r <= data_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register bits
    // ----------------------------------------------------------------
    // hardware clears read trigger
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_r    <= 1'b0;
            rd_ok_r <= 1'b0;
        end else begin
            rd_r    <= rd_start;
            rd_ok_r <= rd_start && loc_ok;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_r <= 1'b0;
        end else if (soft_rst || finish) begin
            wr_r <= 1'b0;
        end else if (wr_start) begin
            wr_r <= 1'b1;
        end
    end

    // Permit is plain read/write; a pin or watchdog reset drops it for safety.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            permit_r <= 1'b0;
        end else if (soft_rst) begin
            permit_r <= 1'b0;
        end else if (ctl_wr) begin
            permit_r <= sfr_req.wdata[nvm_pkg::BIT_PERMIT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            abort_r <= 1'b0;
        end else if (soft_rst && write_busy) begin
            abort_r <= 1'b1;
        end else if (ctl_wr) begin
            abort_r <= sfr_req.wdata[nvm_pkg::BIT_ABORT];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (finish && !soft_rst) begin
            done_r <= 1'b1;
        end else if (ctl_wr) begin
            done_r <= sfr_req.wdata[nvm_pkg::BIT_DONE];
        end
    end

    // ----------------------------------------------------------------
    // Data and location registers
    // ----------------------------------------------------------------
    // data loaded by read
    // A completing read wins over a core write to data in the same cycle.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_r <= nvm_pkg::DATA_RST;
        end else if (rd_r) begin
            data_r <= rd_ok_r ? mem_rdata : 8'h00;
        end else if (sfr_req.wr && sfr_req.idx == nvm_pkg::IDX_DATA) begin
            data_r <= sfr_req.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            loc_r <= nvm_pkg::ADDR_RST;
        end else if (sfr_req.wr && sfr_req.idx == nvm_pkg::IDX_ADDR) begin
            loc_r <= sfr_req.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else begin
            unique case (sfr_ridx)
                nvm_pkg::IDX_CONTROL: sfr_rdata <= {3'h0, done_r, abort_r, permit_r, wr_r, rd_r};
                nvm_pkg::IDX_UNLOCK:  sfr_rdata <= 8'h00;
                nvm_pkg::IDX_DATA:    sfr_rdata <= data_r;
                nvm_pkg::IDX_ADDR:    sfr_rdata <= loc_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Programming interface
    // ----------------------------------------------------------------
    // protection blocks programmer
    // Programmer only gets the array while the core leaves it alone.
    assign prog_ok = !code_protect && (prog_req.addr[7:6] == nvm_pkg::TOP_BITS_OK)
                     && !write_busy && !rd_start;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prog_rd_r  <= 1'b0;
            prog_rdata <= 8'h00;
        end else begin
            prog_rd_r <= prog_req.rd && prog_ok;
            if (prog_rd_r) begin
                prog_rdata <= mem_rdata;
            end else if (prog_req.rd && !prog_ok) begin
                prog_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // Array ports
    // ----------------------------------------------------------------
    // one byte per access
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = wr_addr_r;
        mem_wdata = nvm_pkg::ERASED_VAL;
        if (erase_go_r && !soft_rst) begin
            mem_we = 1'b1;
        end else if (finish && !soft_rst) begin
            mem_we    = 1'b1;
            mem_wdata = wr_data_r;
        end else if (prog_req.wr && prog_ok) begin
            mem_we    = 1'b1;
            mem_waddr = prog_req.addr[5:0];
            mem_wdata = prog_req.wdata;
        end
    end

    assign mem_re    = (rd_start && loc_ok) || (prog_req.rd && prog_ok);
    assign mem_raddr = rd_start ? loc_r[5:0] : prog_req.addr[5:0];

    nvm_cell_array #(
        .DEPTH (nvm_pkg::MEM_DEPTH),
        .AW    (nvm_pkg::MEM_AW)
    ) u_cells (
        .core_clk (core_clk),
        .we       (mem_we),
        .waddr    (mem_waddr),
        .wdata    (mem_wdata),
        .re       (mem_re),
        .raddr    (mem_raddr),
        .rdata    (mem_rdata)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_RD_SELF_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        rd_r |=> !rd_r) else $error("read trigger stayed set");

    AST_RD_LOADS_DATA: assert property (@(posedge core_clk) disable iff (rst)
        rd_start && loc_ok ##1 rd_r |=> data_r == $past(mem_rdata)) else $error("read byte not loaded");

    AST_WR_NEEDS_PERMIT: assert property (@(posedge core_clk) disable iff (rst)
        $rose(wr_r) |-> $past(permit_r)) else $error("write started without permit");

    AST_WR_HELD_BUSY: assert property (@(posedge core_clk) disable iff (rst)
        write_busy |-> wr_r) else $error("write trigger dropped while busy");

    AST_DONE_ON_FINISH: assert property (@(posedge core_clk) disable iff (rst)
        finish && !soft_rst |=> done_r && !wr_r && !write_busy) else $error("done flag not set");

    AST_ABORT_ON_RESET: assert property (@(posedge core_clk) disable iff (rst)
        soft_rst && write_busy |=> abort_r && !wr_r && !write_busy) else $error("abort not flagged");

    AST_ERASE_FIRST: assert property (@(posedge core_clk) disable iff (rst)
        wr_start |=> soft_rst
                     || (mem_we && mem_wdata == nvm_pkg::ERASED_VAL && mem_waddr == $past(loc_r[5:0])))
        else $error("erase did not precede program");

    AST_TOP_BITS_BLOCK: assert property (@(posedge core_clk) disable iff (rst)
        ctl_wr && !loc_ok && !wr_r |=> !wr_r) else $error("write started outside store");

    AST_PROTECT_BLOCKS: assert property (@(posedge core_clk) disable iff (rst)
        code_protect && prog_req.rd |=> !prog_rd_r) else $error("programmer read while protected");

    AST_TIMER_PACE: assert property (@(posedge core_clk) disable iff (rst)
        write_busy && !tick && !soft_rst |=> $stable(wticks_r)) else $error("write time moved off tick");

endmodule // nvm_byte_access

// [inc/nvm_pkg.sv]
// Shared constants and carrier types for the byte-wide nonvolatile data store.
// Assumes one 100 MHz core clock and a core that reaches the store only through four byte registers.
package nvm_pkg;

    // ----------------------------------------------------------------
    // Widths and sizes
    // ----------------------------------------------------------------
    localparam int DATA_W    = 8;  // Every register and every location is one byte.
    localparam int ADDR_W    = 8;  // Location select can express 256 places.
    localparam int MEM_DEPTH = 64; // Only the lowest 64 places exist.
    localparam int MEM_AW    = 6;  // Address bits that reach the array.

    // ----------------------------------------------------------------
    // Register indices on the special function register port
    // ----------------------------------------------------------------
    localparam logic [1:0] IDX_CONTROL = 2'h0; // Control and status bits.
    localparam logic [1:0] IDX_UNLOCK  = 2'h1; // Unlock register, reads as zero.
    localparam logic [1:0] IDX_DATA    = 2'h2; // Data holding register.
    localparam logic [1:0] IDX_ADDR    = 2'h3; // Location select register.

    // ----------------------------------------------------------------
    // Control register field positions
    // ----------------------------------------------------------------
    localparam int BIT_RD     = 0; // Read trigger, set only.
    localparam int BIT_WR     = 1; // Write trigger, set only.
    localparam int BIT_PERMIT = 2; // Write permit.
    localparam int BIT_ABORT  = 3; // Write aborted flag.
    localparam int BIT_DONE   = 4; // Write completed flag.

    // ----------------------------------------------------------------
    // Reset values and fixed data
    // ----------------------------------------------------------------
    localparam logic [7:0] DATA_RST   = 8'h00; // Data holding after reset.
    localparam logic [7:0] ADDR_RST   = 8'h00; // Location select after reset.
    localparam logic [7:0] ERASED_VAL = 8'hff; // Content of an erased location.
    localparam logic [1:0] TOP_BITS_OK = 2'h0; // Upper select bits for a valid place.

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;   // Core clock period.
    localparam int TICK_NS       = 1000; // Period of the write timer tick.
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_TIME_US = 4000; // Whole erase plus program time.
    localparam int WRITE_TICKS_DEF = (WRITE_TIME_US * 1000) / TICK_NS;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    // One register write from the core.
    typedef struct packed {
        logic       wr;    // Write strobe, one cycle.
        logic [1:0] idx;   // Register index.
        logic [7:0] wdata; // Byte written.
    } sfr_req_s;

    // One access from the external programming interface.
    typedef struct packed {
        logic       rd;    // Read strobe, one cycle.
        logic       wr;    // Write strobe, one cycle.
        logic [7:0] addr;  // Location.
        logic [7:0] wdata; // Byte written.
    } prog_req_s;

endpackage

// [hw/nvm_cell_array.sv]
// Byte array that models the nonvolatile cells: one write port, one read port.
// Assumes the caller sequences erase and program; read data come from a register.
`timescale 1ns/1ps

module nvm_cell_array #(
    parameter int DEPTH = nvm_pkg::MEM_DEPTH,
    parameter int AW    = nvm_pkg::MEM_AW
) (
    input  wire logic          core_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Cells are not cleared by reset, as a real nonvolatile store keeps them.
    logic [7:0] cells [DEPTH];

    // Write port.
    always_ff @(posedge core_clk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    // Registered read port, one cycle of latency.
    always_ff @(posedge core_clk) begin
        if (re) begin
            rdata <= cells[raddr];
        end
    end

endmodule // nvm_cell_array

// [testbench/nvm_core_model.sv]
// Behavioural core that reaches the byte store through the register port.
// Assumes the bench calls its tasks; every drive lands by non-blocking assignment at a rising edge.
`timescale 1ns/1ps

module nvm_core_model (
    input  wire logic             core_clk,
    output nvm_pkg::sfr_req_s     sfr_req,
    output logic [1:0]            sfr_ridx,
    input  wire logic [7:0]       sfr_rdata
);
    // Idle port: strobe low, fields parked at zero.
    initial begin
        sfr_req  = '0;
        sfr_ridx = 2'h0;
    end

    task automatic put(input logic [1:0] idx, input logic [7:0] val);
        @(posedge core_clk);
        sfr_req <= '{wr: 1'b1, idx: idx, wdata: val};
        @(posedge core_clk);
        sfr_req <= '0;
    endtask

    // Readback shows one edge after the index, so it is taken just past that edge.
    task automatic get(input logic [1:0] idx, output logic [7:0] val);
        @(posedge core_clk);
        sfr_ridx <= idx;
        @(posedge core_clk);
        #1;
        val = sfr_rdata;
    endtask
endmodule // nvm_core_model

// [testbench/nvm_byte_access_tb_top.sv]
// Bench for the indirect byte store: core model on the register port, programmer and resets here.
// Assumes the package is compiled first; the write timer is shortened to 4 ticks of 100 cycles.
`timescale 1ns/1ps

module nvm_byte_access_tb_top;
    localparam logic [1:0] CTL = nvm_pkg::IDX_CONTROL;
    localparam logic [1:0] DAT = nvm_pkg::IDX_DATA;
    localparam logic [1:0] ADR = nvm_pkg::IDX_ADDR;
    logic               core_clk;
    logic               rst;
    nvm_pkg::sfr_req_s  sfr_req;
    logic [1:0]         sfr_ridx;
    logic [7:0]         sfr_rdata;
    logic               pin_n;
    logic               wdog;
    logic               protect;
    nvm_pkg::prog_req_s prog_req;
    logic [7:0]         prog_rdata;
    logic               write_busy;
    int                 bad_count = 0; // Mismatches seen.
    int                 checks    = 0; // Comparisons made.

    nvm_byte_access #(.WRITE_TICKS(4)) dut (.core_clk(core_clk), .rst(rst), .sfr_req(sfr_req),
        .sfr_ridx(sfr_ridx), .sfr_rdata(sfr_rdata), .external_reset_pin_n(pin_n), .watchdog_timer_reset(wdog),
        .code_protect(protect), .prog_req(prog_req), .prog_rdata(prog_rdata), .write_busy(write_busy));
    nvm_core_model core (.core_clk(core_clk), .sfr_req(sfr_req), .sfr_ridx(sfr_ridx), .sfr_rdata(sfr_rdata));

    // ----------------------------------------------------------------
    // Shared checks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_is(input logic [1:0] idx, input string what, input logic [7:0] exp);
        logic [7:0] v;
        core.get(idx, v);
        chk(what, exp, v);
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Bounded wait for the write to end; a hang is a mismatch.
    task automatic wait_idle(output int n);
        n = 0;
        while (write_busy !== 1'b0 && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 1000) begin
            chk("write_busy", 8'h00, 8'h01);
            give_verdict();
        end
    endtask

    task automatic start_write(input logic [7:0] a, input logic [7:0] d);
        core.put(ADR, a);
        core.put(DAT, d);
        core.put(CTL, 8'h04);
        core.put(CTL, 8'h06);
        @(posedge core_clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic read_back(input logic [7:0] a, input logic [7:0] d);
        core.put(ADR, a);
        core.put(CTL, 8'h01);
        reg_is(CTL, "control_rd", 8'h00);
        reg_is(DAT, "data", d);
    endtask

    task automatic write_and_read(input logic [7:0] a, input logic [7:0] d);
        int n;
        start_write(a, d);
        chk("busy", 8'h01, {7'h00, write_busy});
        wait_idle(n);
        chk("write_time_ok", 8'h01, {7'h00, n >= 290 && n <= 500});
        reg_is(CTL, "control_done", 8'h14);
        repeat (20) @(posedge core_clk);
        reg_is(CTL, "control_sticky", 8'h14);
        core.put(CTL, 8'h00);
        reg_is(CTL, "control_clear", 8'h00);
        read_back(a, d);
    endtask

    task automatic refused_writes();
        core.put(ADR, 8'h05);
        core.put(CTL, 8'h02);
        @(posedge core_clk);
        #1;
        chk("busy_no_permit", 8'h00, {7'h00, write_busy});
        start_write(8'h40, 8'h11);
        chk("busy_top_bits", 8'h00, {7'h00, write_busy});
        reg_is(CTL, "control_top_bits", 8'h04);
        core.put(CTL, 8'h00);
        read_back(8'h40, 8'h00);
    endtask

    task automatic abort_case(input logic by_pin);
        int n;
        start_write(8'h10, 8'h77);
        repeat (50) @(posedge core_clk);
        pin_n <= !by_pin;
        wdog  <= !by_pin;
        repeat (5) @(posedge core_clk);
        pin_n <= 1'b1;
        wdog  <= 1'b0;
        repeat (4) @(posedge core_clk);
        wait_idle(n);
        reg_is(CTL, "control_abort", 8'h08);
        core.put(CTL, 8'h00);
        // The erase ran before the cut, so the place now reads as erased.
        read_back(8'h10, nvm_pkg::ERASED_VAL);
    endtask

    task automatic programmer_read(input logic prot, input logic [7:0] exp);
        @(posedge core_clk);
        protect  <= prot;
        prog_req <= '{rd: 1'b1, wr: 1'b0, addr: 8'h00, wdata: 8'h00};
        @(posedge core_clk);
        prog_req <= '0;
        @(posedge core_clk);
        #1;
        chk("prog_rdata", exp, prog_rdata);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        rst      = 1'b1;
        pin_n    = 1'b1;
        wdog     = 1'b0;
        protect  = 1'b0;
        prog_req = '0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        reg_is(CTL, "control_rst", 8'h00);
        reg_is(DAT, "data_rst", nvm_pkg::DATA_RST);
        reg_is(ADR, "location_rst", nvm_pkg::ADDR_RST);
        reg_is(nvm_pkg::IDX_UNLOCK, "unlock", 8'h00);
        write_and_read(8'h00, 8'ha5);
        write_and_read(8'h3f, 8'h3c);
        refused_writes();
        abort_case(1'b0);
        abort_case(1'b1);
        programmer_read(1'b0, 8'ha5);
        programmer_read(1'b1, 8'h00);
        read_back(8'h00, 8'ha5);
        give_verdict();
    end
endmodule // nvm_byte_access_tb_top
